// ===== verilog/clock_mode_pkg.sv
// Purpose: Shared constants and types for the CPU clock and mode control block.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Every offset and field position, and the mode register reset value, live here.
package clock_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BITOP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register layout and reset value.
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 6;
  localparam int SRC_BIT = 5;
  localparam int MAIN_OFF_BIT = 4;
  localparam int INT_OFF_BIT = 3;
  localparam int OPM_HI = 1;
  localparam int OPM_LO = 0;
  // Bits 5, 1 and 0 accept one write after reset.
  localparam logic [7:0] LOCK_MASK = 8'h23;
  // Division code meaning double speed.
  localparam logic [1:0] DIV_DOUBLE = 2'h0;

  // Single-bit operation register layout.
  localparam int BITOP_IDX_HI = 2;
  localparam int BITOP_SET_BIT = 8;

  // Status register layout.
  localparam int ST_SRC_LO = 0;
  localparam int ST_SRC_HI = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_CHOSEN = 3;
  localparam int ST_MISUSE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Active clock source, Gray along internal, ceramic, RC.
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_CERAMIC = 2'h1,
    SRC_RC = 2'h3
  } clk_src_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_access_t;

endpackage

// ===== verilog/apb_slave_port.sv
// Purpose: APB slave handshake with one wait-free access phase.
// Assumes: Read data and error decode are combinational from the owner.
// Notes:   Answers are registered in the setup cycle, so pready is a flop.
`timescale 1ns/1ps
module apb_slave_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Bus request and answer
  input wire clock_mode_pkg::apb_req_t req,
  output logic pready,
  output logic [clock_mode_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // Register side
  input wire logic [clock_mode_pkg::DATA_W-1:0] rdData,
  input wire logic rdErr,
  output clock_mode_pkg::reg_access_t acc
);

  logic setup;

  assign setup = req.sel & ~req.enable;
  assign acc.wr = clkEn & req.sel & req.enable & pready & req.write;
  assign acc.addr = req.addr;
  assign acc.wdata = req.wdata;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= setup;
      prdata <= (setup & ~req.write) ? rdData : '0;
      pslverr <= setup & rdErr;
    end
  end

endmodule

// ===== verilog/clock_source_select.sv
// Purpose: Turns the mode register into registered clock controls.
// Assumes: The source is only taken from the mode bit once it was chosen.
// Notes:   The running source's oscillator is never switched off.
`timescale 1ns/1ps
module clock_source_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Mode state
  input wire logic [7:0] modeReg,
  input wire logic chosen,
  // Clock controls
  output clock_mode_pkg::clk_src_t srcSel,
  output logic [1:0] divSel,
  output logic mainOscEn,
  output logic intOscEn
);

  clock_mode_pkg::clk_src_t wantSrc;
  clock_mode_pkg::clk_src_t srcNxt;
  logic mainOff;

  assign mainOff = modeReg[clock_mode_pkg::MAIN_OFF_BIT];
  assign wantSrc = modeReg[clock_mode_pkg::SRC_BIT] ? clock_mode_pkg::SRC_RC
                                                    : clock_mode_pkg::SRC_CERAMIC;
  // Without a chosen, running main oscillator the core stays on internal.
  assign srcNxt = (!chosen || mainOff) ? clock_mode_pkg::SRC_INTERNAL : wantSrc;

  always_ff @(posedge mclk) begin
    if (rst) begin
      srcSel <= clock_mode_pkg::SRC_INTERNAL;
      divSel <= clock_mode_pkg::MODE_RESET[clock_mode_pkg::DIV_HI:clock_mode_pkg::DIV_LO];
      mainOscEn <= ~clock_mode_pkg::MODE_RESET[clock_mode_pkg::MAIN_OFF_BIT];
      intOscEn <= 1'b1;
    end else if (clkEn) begin
      srcSel <= srcNxt;
      divSel <= modeReg[clock_mode_pkg::DIV_HI:clock_mode_pkg::DIV_LO];
      mainOscEn <= ~mainOff;
      intOscEn <= ~modeReg[clock_mode_pkg::INT_OFF_BIT] |
                  (srcNxt == clock_mode_pkg::SRC_INTERNAL);
    end
  end

endmodule

// ===== verilog/cpu_clock_mode_control.sv
// Purpose: CPU operating mode register with clock source and divider control.
// Assumes: Software reaches the registers over APB; all inputs share mclk.
// Notes:   Contract
// Contract
// - After reset the core runs from the internal oscillator.
// - Mode bit 5 picks ceramic resonator or RC oscillator.
// - Bits 5, 1, 0 accept one write after reset, then ignore writes.
// - A single-bit set or clear on any bit also locks bits 5, 1, 0.
// - Bits 7:6 divide ratio, bit 4 main clock, bit 3 internal oscillator.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cpu_clock_mode_control (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_mode_pkg::ADDR_W-1:0] paddr,
  input wire logic [clock_mode_pkg::DATA_W-1:0] pwdata,
  output logic [clock_mode_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock controls
  output clock_mode_pkg::clk_src_t clkSrcSel,
  output logic [1:0] divSel,
  output logic mainOscEn,
  output logic intOscEn,
  // Operating mode and lock state
  output logic [1:0] opMode,
  output logic modeLocked
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  clock_mode_pkg::apb_req_t req;
  clock_mode_pkg::reg_access_t acc;
  logic [clock_mode_pkg::DATA_W-1:0] rdData;
  logic rdErr;

  assign req.sel = psel;
  assign req.enable = penable;
  assign req.write = pwrite;
  assign req.addr = paddr;
  assign req.wdata = pwdata;

  apb_slave_port u_port (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .req(req),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rdData(rdData),
    .rdErr(rdErr),
    .acc(acc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic lock_r;
  logic lock_nxt;
  logic chosen_r;
  logic chosen_nxt;
  logic misuse_r;
  logic misuse_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic hitMode;
  logic hitBit;
  logic hitStatus;
  logic hitAny;

  assign hitMode = (paddr == clock_mode_pkg::OFS_MODE);
  assign hitBit = (paddr == clock_mode_pkg::OFS_BITOP);
  assign hitStatus = (paddr == clock_mode_pkg::OFS_STATUS);
  assign hitAny = hitMode | hitBit | hitStatus;

  ////////////////////////////////////////////////////////////////////////////
  // Write paths.

  logic modeWr;
  logic bitWr;
  logic anyWr;
  logic [2:0] bitIdx;
  logic bitSet;
  logic [7:0] bitMask;
  logic [7:0] bitVal;
  logic [7:0] writeVal;
  logic touchSrc;

  assign modeWr = acc.wr & (acc.addr == clock_mode_pkg::OFS_MODE);
  assign bitWr = acc.wr & (acc.addr == clock_mode_pkg::OFS_BITOP);
  assign anyWr = modeWr | bitWr;

  // Single-bit set or clear, a read-modify-write of the mode register.
  assign bitIdx = acc.wdata[clock_mode_pkg::BITOP_IDX_HI:0];
  assign bitSet = acc.wdata[clock_mode_pkg::BITOP_SET_BIT];
  assign bitMask = 8'h01 << bitIdx;
  assign bitVal = bitSet ? (mode_r | bitMask) : (mode_r & ~bitMask);

  assign writeVal = modeWr ? acc.wdata[7:0] : bitVal;

  // write-once bits
  // Once locked, bits 5, 1 and 0 keep their value; other bits stay writable.
  assign mode_nxt = !anyWr ? mode_r :
                    lock_r ? ((mode_r & clock_mode_pkg::LOCK_MASK) |
                              (writeVal & ~clock_mode_pkg::LOCK_MASK)) :
                    writeVal;

  // bit-op locking
  // Any full write or single-bit operation closes the write-once window.
  assign lock_nxt = lock_r | anyWr;

  // source choice
  // The source counts as chosen only when bit 5 was written while open.
  assign touchSrc = modeWr | (bitWr & (bitIdx == 3'(clock_mode_pkg::SRC_BIT)));
  assign chosen_nxt = chosen_r | (touchSrc & ~lock_r);

  // Flags double speed while the RC oscillator drives the core.
  assign misuse_nxt = (clkSrcSel == clock_mode_pkg::SRC_RC) &
                      (divSel == clock_mode_pkg::DIV_DOUBLE);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_r <= clock_mode_pkg::MODE_RESET;
      lock_r <= 1'b0;
      chosen_r <= 1'b0;
      misuse_r <= 1'b0;
    end else if (clkEn) begin
      mode_r <= mode_nxt;
      lock_r <= lock_nxt;
      chosen_r <= chosen_nxt;
      misuse_r <= misuse_nxt;
    end
  end

  assign opMode = mode_r[clock_mode_pkg::OPM_HI:clock_mode_pkg::OPM_LO];
  assign modeLocked = lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and divider control.

  clock_source_select u_sel (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .modeReg(mode_r),
    .chosen(chosen_r),
    .srcSel(clkSrcSel),
    .divSel(divSel),
    .mainOscEn(mainOscEn),
    .intOscEn(intOscEn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus errors.

  logic [clock_mode_pkg::DATA_W-1:0] statusWord;

  assign statusWord = {27'h0, misuse_r, chosen_r, lock_r, clkSrcSel};
  assign rdData = hitMode ? {24'h0, mode_r} :
                  hitStatus ? statusWord :
                  32'h0;
  // Unmapped addresses and writes to the status word answer with an error.
  assign rdErr = ~hitAny | (hitStatus & pwrite);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  clock_mode_pkg::clk_src_t wantSrc;

  assign wantSrc = mode_r[clock_mode_pkg::SRC_BIT] ? clock_mode_pkg::SRC_RC
                                                   : clock_mode_pkg::SRC_CERAMIC;

  a_reset_internal:
  assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> (clkSrcSel == clock_mode_pkg::SRC_INTERNAL) && intOscEn)
  else $error("Core did not start on the internal oscillator.");

  a_unchosen_internal:
  assert property (@(posedge mclk) disable iff (rst)
    !chosen_r && clkEn |=> clkSrcSel == clock_mode_pkg::SRC_INTERNAL)
  else $error("Source left internal before software chose one.");

  a_source_follows:
  assert property (@(posedge mclk) disable iff (rst)
    clkEn && chosen_r && !mode_r[clock_mode_pkg::MAIN_OFF_BIT]
    |=> clkSrcSel == $past(wantSrc))
  else $error("Active source does not follow mode bit 5.");

  a_first_write:
  assert property (@(posedge mclk) disable iff (rst)
    modeWr && !lock_r
    |=> lock_r && ((mode_r & clock_mode_pkg::LOCK_MASK) ==
                   ($past(pwdata[7:0]) & clock_mode_pkg::LOCK_MASK)))
  else $error("First mode write was not taken or did not lock.");

  a_locked_hold:
  assert property (@(posedge mclk) disable iff (rst)
    lock_r ##1 1'b1
    |-> (mode_r & clock_mode_pkg::LOCK_MASK) ==
        ($past(mode_r) & clock_mode_pkg::LOCK_MASK))
  else $error("A locked mode bit changed.");

  a_bitop_locks:
  assert property (@(posedge mclk) disable iff (rst)
    bitWr |=> lock_r ##1 lock_r)
  else $error("Single-bit operation did not lock the mode bits.");

  a_divider_map:
  assert property (@(posedge mclk) disable iff (rst)
    clkEn |=> divSel == $past(mode_r[clock_mode_pkg::DIV_HI:clock_mode_pkg::DIV_LO])
              && mainOscEn == !$past(mode_r[clock_mode_pkg::MAIN_OFF_BIT]))
  else $error("Divider or main oscillator control mismatches the mode register.");

  a_lock_sticky:
  assert property (@(posedge mclk) disable iff (rst)
    lock_r |=> lock_r)
  else $error("Lock cleared without a reset.");

  a_reset_unlock:
  assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> !lock_r && !chosen_r && (mode_r == clock_mode_pkg::MODE_RESET))
  else $error("Reset did not clear the lock.");

  a_reset_outputs:
  assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> !pready && (mainOscEn == !clock_mode_pkg::MODE_RESET[clock_mode_pkg::MAIN_OFF_BIT])
    && (divSel == clock_mode_pkg::MODE_RESET[clock_mode_pkg::DIV_HI:clock_mode_pkg::DIV_LO]))
  else $error("Bus answer or clock controls left their reset values.");

  a_internal_osc_runs:
  assert property (@(posedge mclk) disable iff (rst)
    clkSrcSel == clock_mode_pkg::SRC_INTERNAL |-> intOscEn)
  else $error("Internal oscillator off while it drives the core.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the write paths and the bus answer.

  a_locked_write_kept:
  assert property (@(posedge mclk) disable iff (rst)
    modeWr && lock_r
    |=> (mode_r & ~clock_mode_pkg::LOCK_MASK) ==
        ($past(pwdata[7:0]) & ~clock_mode_pkg::LOCK_MASK))
  else $error("A writable mode bit ignored a write after the lock.");

  a_bitop_open:
  assert property (@(posedge mclk) disable iff (rst)
    bitWr && !lock_r |=> mode_r[$past(bitIdx)] == $past(bitSet))
  else $error("Single-bit operation before the lock was not applied.");

  a_status_refused:
  assert property (@(posedge mclk) disable iff (rst)
    clkEn && psel && !penable && pwrite && (paddr == clock_mode_pkg::OFS_STATUS)
    |=> pslverr)
  else $error("Write to the status word was not refused.");

  a_ready_single:
  assert property (@(posedge mclk) disable iff (rst)
    clkEn && pready |=> !pready)
  else $error("Bus answer stood longer than one cycle.");

  a_read_idle:
  assert property (@(posedge mclk) disable iff (rst)
    !pready |-> prdata == '0)
  else $error("Read data shown outside the access cycle.");

  a_chosen_closed:
  assert property (@(posedge mclk) disable iff (rst)
    lock_r && !chosen_r |=> !chosen_r)
  else $error("Source was chosen after the lock closed.");

  a_chosen_sticky:
  assert property (@(posedge mclk) disable iff (rst)
    chosen_r |=> chosen_r)
  else $error("Source choice was lost without a reset.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the clock controls.

  a_main_off_internal:
  assert property (@(posedge mclk) disable iff (rst)
    clkEn && mode_r[clock_mode_pkg::MAIN_OFF_BIT]
    |=> clkSrcSel == clock_mode_pkg::SRC_INTERNAL)
  else $error("Core left on a stopped main oscillator.");

endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the CPU clock source and mode control block.
// Assumes: APB answers within a bounded number of cycles; clkEn held high.
// Notes:   A small reference model tracks the mode value, the lock and source choice.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst, clkEn, psel, penable, pwrite, pready, pslverr, mainOscEn, intOscEn;
  logic modeLocked;
  logic [7:0] paddr, modeM;
  logic [31:0] pwdata, prdata, rngState;
  logic [1:0] divSel, opMode;
  clock_mode_pkg::clk_src_t clkSrcSel;
  logic lockM, chosenM;
  int n_errors, comparisons, cycles;

  cpu_clock_mode_control cpu_clock_mode_control_inst (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clkSrcSel(clkSrcSel), .divSel(divSel), .mainOscEn(mainOscEn),
    .intOscEn(intOscEn), .opMode(opMode), .modeLocked(modeLocked)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
    comparisons++;
    if (got !== expv) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, expv, got);
    end
  endtask

  // Master holds the request until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    modeM = clock_mode_pkg::MODE_RESET;
    lockM = 1'b0;
    chosenM = 1'b0;
  endtask

  function automatic clock_mode_pkg::clk_src_t exp_src();
    if (!chosenM || modeM[clock_mode_pkg::MAIN_OFF_BIT]) return clock_mode_pkg::SRC_INTERNAL;
    return modeM[clock_mode_pkg::SRC_BIT] ? clock_mode_pkg::SRC_RC : clock_mode_pkg::SRC_CERAMIC;
  endfunction

  // Full write when bitOp is 0, otherwise a single-bit set or clear.
  task automatic do_op(input logic bitOp, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    logic [7:0] m;
    m = 8'h01 << d[2:0];
    if (bitOp) begin
      apb(1'b1, clock_mode_pkg::OFS_BITOP, d, rd, er);
      if (!(lockM && (m & clock_mode_pkg::LOCK_MASK))) begin
        modeM = d[8] ? (modeM | m) : (modeM & ~m);
      end
      if (!lockM && d[2:0] == 3'h5) chosenM = 1'b1;
    end else begin
      apb(1'b1, clock_mode_pkg::OFS_MODE, d, rd, er);
      modeM = lockM ? ((modeM & clock_mode_pkg::LOCK_MASK) | (d[7:0] & ~clock_mode_pkg::LOCK_MASK))
                    : d[7:0];
      if (!lockM) chosenM = 1'b1;
    end
    lockM = 1'b1;
    chk("op error", 32'h0, {31'h0, er});
  endtask

  task automatic check_all();
    logic [31:0] rd;
    logic er;
    logic [1:0] es;
    es = exp_src();
    repeat (3) @(posedge mclk);
    chk("clkSrcSel", {30'h0, es}, {30'h0, clkSrcSel});
    chk("divSel", {30'h0, modeM[7:6]}, {30'h0, divSel});
    chk("mainOscEn", {31'h0, !modeM[4]}, {31'h0, mainOscEn});
    chk("intOscEn", {31'h0, (es == 2'h0) | !modeM[3]}, {31'h0, intOscEn});
    chk("opMode", {30'h0, modeM[1:0]}, {30'h0, opMode});
    chk("modeLocked", {31'h0, lockM}, {31'h0, modeLocked});
    apb(1'b0, clock_mode_pkg::OFS_MODE, 32'h0, rd, er);
    chk("mode", {24'h0, modeM}, rd);
    apb(1'b0, clock_mode_pkg::OFS_STATUS, 32'h0, rd, er);
    chk("status", {27'h0, es == 2'h3 && modeM[7:6] == clock_mode_pkg::DIV_DOUBLE,
                   chosenM, lockM, es}, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd, r;
    logic er;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    rngState = 32'ha484;
    rst = 1'b1;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    do_reset();
    check_all();
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, clock_mode_pkg::OFS_STATUS, 32'hff, rd, er);
    chk("status write err", 32'h1, {31'h0, er});
    check_all();
    do_op(1'b1, 32'h106);
    do_op(1'b0, 32'h23);
    check_all();
    do_reset();
    do_op(1'b1, 32'h105);
    do_op(1'b1, 32'h005);
    check_all();
    do_reset();
    do_op(1'b0, 32'h00);
    do_op(1'b0, 32'hff);
    check_all();
    for (int k = 0; k < 10; k++) begin
      do_reset();
      check_all();
      for (int j = 0; j < 5; j++) begin
        r = xs();
        do_op(r[0], {23'h0, r[8], r[15:8]});
        check_all();
      end
    end
    report_and_stop();
  end
endmodule
